// ===== hdl/protect_pkg.sv
// Package with constants and types for the block protection logic.
package protect_pkg;
  localparam int unsigned NUM_BLOCKS = 256;
  localparam int unsigned BLK_W = 8;
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned BLOCK_LSB = 18;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned PROG_TIME_US = 200;
  localparam int unsigned ERASE_TIME_US = 1000;
  localparam int unsigned PROG_CYCLES = (PROG_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ERASE_CYCLES = (ERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 20;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_EXT = 8'h08;
  localparam logic [7:0] ADDR_QUERY = 8'h0C;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_PERR = 1;
  localparam int unsigned ST_EERR = 2;
  localparam int unsigned ST_PROT = 3;
  localparam int unsigned ST_LOCK = 4;

  typedef enum logic [2:0]
  {
    CMD_NONE = 3'h0,
    CMD_PERSIST_PROG = 3'h1,
    CMD_PERSIST_ERASE = 3'h2,
    CMD_PERSIST_READ = 3'h3,
    CMD_DYNAMIC_WRITE = 3'h4,
    CMD_ARRAY_PROG = 3'h5,
    CMD_ARRAY_ERASE = 3'h6,
    CMD_LOCK_CLEAR = 3'h7
  } cmd_e;

  typedef struct packed
  {
    cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic value;
  } cmd_s;
endpackage : protect_pkg

// ===== hdl/op_timer.sv
// Down counter that times a non-volatile program or erase operation.
`timescale 1ns/10ps
module op_timer
  import protect_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [CNT_W-1:0] load,
  output logic done
);
  logic [CNT_W-1:0] count;
  logic run;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= '0;
      run <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        count <= load;
        run <= 1'b1;
      end
      else if (run)
      begin
        if (count <= 20'h00001)
        begin
          run <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          count <= count - 20'h00001;
        end
      end
    end
  end
endmodule : op_timer

// ===== hdl/sector_block_protect_bits.sv
// Per-block persistent and dynamic write protection with a register port.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
module sector_block_protect_bits
  import protect_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic array_read_ok,
  output logic array_op_grant
);
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b001,
    S_PROG = 3'b010,
    S_ERASE = 3'b100
  } state_e;

  state_e state;
  logic [NUM_BLOCKS-1:0] persistent_protect_bit;
  logic [NUM_BLOCKS-1:0] dynamic_protect_bit;
  logic persistent_lock_bit;
  logic [BLK_W-1:0] op_block;
  logic [BLK_W-1:0] query_block;
  logic query_value;
  logic query_prot;
  logic perr;
  logic eerr;
  logic prot_err;
  logic timer_start;
  logic [CNT_W-1:0] timer_load;
  logic timer_done;
  logic busy;
  cmd_s cmd;
  logic cmd_valid;
  logic [BLK_W-1:0] cmd_block;
  logic addr_ok;
  logic next_busy;

  function automatic logic [BLK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
    block_of = a[ADDR_W-1:BLOCK_LSB];
  endfunction : block_of

  function automatic logic block_protected(input logic pbit, input logic dbit);
    block_protected = !pbit || !dbit;
  endfunction : block_protected

  assign cmd = cmd_s'(reg_wdata[ADDR_W+3:0]);
  assign cmd_valid = reg_wr && (reg_addr == ADDR_CTRL);
  assign cmd_block = block_of(cmd.addr);
  assign addr_ok = (cmd.addr[BLOCK_LSB-1:0] == '0);
  assign busy = (state != S_IDLE);
  assign next_busy = busy && !timer_done;

  // Command sequencing for persistent bit program and erase.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      op_block <= '0;
      timer_start <= 1'b0;
      timer_load <= '0;
    end
    else
    begin
      timer_start <= 1'b0;
      unique case (state)
        S_IDLE:
        begin
          if (cmd_valid && persistent_lock_bit)
          begin
            if (cmd.cmd == CMD_PERSIST_PROG)
            begin
              state <= S_PROG;
              op_block <= cmd_block;
              timer_start <= 1'b1;
              timer_load <= CNT_W'(PROG_CYCLES);
            end
            else if (cmd.cmd == CMD_PERSIST_ERASE)
            begin
              state <= S_ERASE;
              timer_start <= 1'b1;
              timer_load <= CNT_W'(ERASE_CYCLES);
            end
          end
        end
        S_PROG, S_ERASE:
        begin
          if (timer_done)
          begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  op_timer u_timer
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(timer_start),
    .load(timer_load),
    .done(timer_done)
  );

  // Non-volatile bits are modelled as flops reset to the erased state.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      persistent_protect_bit <= '1;
    end
    else if (timer_done && state == S_PROG)
    begin
      persistent_protect_bit[op_block] <= 1'b0;
    end
    else if (timer_done && state == S_ERASE)
    begin
      persistent_protect_bit <= '1;
    end
  end

  // Dynamic bits clear to unprotected on any reset.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dynamic_protect_bit <= '1;
    end
    else if (cmd_valid && !busy && cmd.cmd == CMD_DYNAMIC_WRITE)
    begin
      dynamic_protect_bit[cmd_block] <= cmd.value;
    end
  end

  // Lock bit can only be cleared; reset sets it again.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      persistent_lock_bit <= 1'b1;
    end
    else if (cmd_valid && !busy && cmd.cmd == CMD_LOCK_CLEAR)
    begin
      persistent_lock_bit <= 1'b0;
    end
  end

  // Query results, error flags and array grants.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      query_block <= '0;
      query_value <= 1'b1;
      query_prot <= 1'b0;
      perr <= 1'b0;
      eerr <= 1'b0;
      prot_err <= 1'b0;
      array_op_grant <= 1'b0;
    end
    else
    begin
      array_op_grant <= 1'b0;
      if (cmd_valid && !busy)
      begin
        unique case (cmd.cmd)
          CMD_PERSIST_READ:
          begin
            query_block <= cmd_block;
            query_value <= addr_ok ? persistent_protect_bit[cmd_block] : 1'b0;
            query_prot <= block_protected(persistent_protect_bit[cmd_block],
                                          dynamic_protect_bit[cmd_block]);
          end
          CMD_PERSIST_PROG:
          begin
            perr <= !persistent_lock_bit;
            prot_err <= !persistent_lock_bit;
          end
          CMD_PERSIST_ERASE:
          begin
            eerr <= !persistent_lock_bit;
            prot_err <= !persistent_lock_bit;
          end
          CMD_ARRAY_PROG, CMD_ARRAY_ERASE:
          begin
            if (block_protected(persistent_protect_bit[cmd_block],
                                dynamic_protect_bit[cmd_block]))
            begin
              prot_err <= 1'b1;
              perr <= (cmd.cmd == CMD_ARRAY_PROG);
              eerr <= (cmd.cmd == CMD_ARRAY_ERASE);
            end
            else
            begin
              array_op_grant <= 1'b1;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Array reads are blocked while a persistent bit program runs.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      array_read_ok <= 1'b1;
    end
    else
    begin
      array_read_ok <= !(next_busy && state == S_PROG) &&
                       !(cmd_valid && !busy && persistent_lock_bit &&
                         cmd.cmd == CMD_PERSIST_PROG);
    end
  end

  // Register read port with one cycle latency.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_STATUS: reg_rdata <= {27'h0000000, persistent_lock_bit, prot_err, eerr, perr,
                                   busy};
        ADDR_EXT: reg_rdata <= {29'h00000000, state == S_ERASE, state == S_PROG,
                                busy};
        ADDR_QUERY: reg_rdata <= {22'h000000, query_prot, query_value, query_block};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h00000000;
    end
  end

  a_prog_clears_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == S_PROG && timer_done) |=> !persistent_protect_bit[$past(op_block)])
    else $error("programmed persistent bit not zero");

  a_prog_one_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == S_PROG && timer_done) |=> persistent_protect_bit ==
      ($past(persistent_protect_bit) & ~({{(NUM_BLOCKS-1){1'b0}}, 1'b1} << $past(op_block))))
    else $error("program touched another persistent bit");

  a_erase_sets_all: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == S_ERASE && timer_done) |=> (&persistent_protect_bit))
    else $error("erase left a persistent bit at zero");

  a_lock_refuses: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cmd_valid && !busy && !persistent_lock_bit &&
     (cmd.cmd == CMD_PERSIST_PROG || cmd.cmd == CMD_PERSIST_ERASE)) |=> (state == S_IDLE))
    else $error("locked persistent bits began changing");

  a_lock_sticks: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !persistent_lock_bit |=> !persistent_lock_bit)
    else $error("lock bit set again without reset");

  a_persist_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == S_IDLE) |=> $stable(persistent_protect_bit))
    else $error("persistent bits changed with no operation");

  a_dynamic_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cmd_valid && !busy && cmd.cmd == CMD_DYNAMIC_WRITE)
    |=> dynamic_protect_bit[$past(cmd_block)] == $past(cmd.value))
    else $error("dynamic bit not stored");

  a_no_read_prog: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == S_PROG && !timer_done) |=> !array_read_ok)
    else $error("array read allowed during program");

  a_read_restored: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == S_PROG && timer_done) |=> array_read_ok)
    else $error("array read still blocked after program");

  a_reject_protected: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cmd_valid && !busy && cmd.cmd == CMD_ARRAY_PROG &&
     !persistent_protect_bit[cmd_block]) |=> (!array_op_grant && prot_err))
    else $error("protected block granted");

  a_dyn_masked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cmd_valid && !busy && cmd.cmd == CMD_ARRAY_ERASE && !persistent_protect_bit[cmd_block])
    |=> (!array_op_grant && eerr))
    else $error("erase granted on persistently protected block");

  a_grant_open: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cmd_valid && !busy && (cmd.cmd == CMD_ARRAY_PROG || cmd.cmd == CMD_ARRAY_ERASE) &&
     persistent_protect_bit[cmd_block] && dynamic_protect_bit[cmd_block])
    |=> array_op_grant)
    else $error("unprotected block refused");

  a_busy_status: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_STATUS) |=> reg_rdata[ST_BUSY] == $past(busy))
    else $error("status busy mismatch");

  a_ext_erase: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_EXT) |=> reg_rdata[2] == $past(state == S_ERASE))
    else $error("extended erase flag mismatch");

  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");

  a_prog_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
    timer_start |=> !timer_done [*8])
    else $error("operation finished too early");

  a_query_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cmd_valid && !busy && cmd.cmd == CMD_PERSIST_READ && addr_ok)
    |=> query_value == $past(persistent_protect_bit[cmd_block]))
    else $error("persistent read wrong");
endmodule : sector_block_protect_bits

// ===== tb/host_model.sv
// Register-port host that issues protection commands to the block.
`timescale 1ns/10ps
module host_model
  import protect_pkg::*;
(
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Block commands carry the caller's address unchanged; unused low bits are not forced to zero.
  task automatic cmd(input cmd_e c, input logic [25:0] a, input logic v);
    @(posedge sys_clk);
    reg_addr <= ADDR_CTRL;
    reg_wdata <= {2'h0, c, a, v};
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~reg_wdata;
  endtask : cmd

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : host_model

// ===== tb/sector_block_protect_bits_bench.sv
// Self-checking bench for the block protection logic.
`timescale 1ns/10ps
module sector_block_protect_bits_bench
  import protect_pkg::*;
;
  typedef struct packed
  {
    cmd_e c;
    logic [7:0] blk;
    logic v;
    logic g;
  } row_s;

  logic sys_clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic array_read_ok;
  logic array_op_grant;
  logic [31:0] d;
  int failures;
  int comparisons;
  int n;
  row_s rows [8] = '{
    '{CMD_ARRAY_PROG, 8'h05, 1'b0, 1'b1},
    '{CMD_DYNAMIC_WRITE, 8'h05, 1'b0, 1'b0},
    '{CMD_ARRAY_PROG, 8'h05, 1'b0, 1'b0},
    '{CMD_ARRAY_ERASE, 8'h05, 1'b0, 1'b0},
    '{CMD_ARRAY_ERASE, 8'h06, 1'b0, 1'b1},
    '{CMD_DYNAMIC_WRITE, 8'h05, 1'b1, 1'b0},
    '{CMD_ARRAY_ERASE, 8'h05, 1'b0, 1'b1},
    '{CMD_ARRAY_PROG, 8'hFF, 1'b0, 1'b1}
  };

  host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sector_block_protect_bits dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .array_read_ok(array_read_ok), .array_op_grant(array_op_grant));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Busy must still stand shortly before the nominal time and clear soon after it.
  task automatic wait_idle(input int cyc);
    repeat (cyc - 12) @(posedge sys_clk);
    host.rd(ADDR_STATUS, d);
    check("busy late", {31'h0, d[ST_BUSY]}, 32'h1);
    for (n = 0; n < 20 && d[ST_BUSY] !== 1'b0; n++)
      host.rd(ADDR_STATUS, d);
    check("busy end", {31'h0, d[ST_BUSY]}, 32'h0);
    if (d[ST_BUSY] !== 1'b0)
      conclude();
  endtask : wait_idle

  task automatic query(input logic [25:0] a, input logic [31:0] exp);
    host.cmd(CMD_PERSIST_READ, a, 1'b0);
    host.rd(ADDR_QUERY, d);
    check("query", d, exp);
  endtask : query

  task automatic grant(input logic [7:0] blk, input logic exp);
    host.cmd(CMD_ARRAY_PROG, {blk, 18'h0}, 1'b0);
    #1;
    check("grant", {31'h0, array_op_grant}, {31'h0, exp});
  endtask : grant

  initial
  begin
    failures = 0;
    comparisons = 0;
    rst_b = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    host.rd(ADDR_STATUS, d);
    check("status reset", d, 32'h10);
    @(posedge sys_clk);
    #1;
    check("rdata idle", reg_rdata, 32'h0);
    query({8'h00, 18'h0}, 32'h100);
    for (int i = 0; i < 8; i++)
    begin
      host.cmd(rows[i].c, {rows[i].blk, 18'h0}, rows[i].v);
      #1;
      check("row grant", {31'h0, array_op_grant}, {31'h0, rows[i].g});
    end
    host.cmd(CMD_PERSIST_PROG, {8'h07, 18'h0}, 1'b0);
    host.cmd(CMD_DYNAMIC_WRITE, {8'h03, 18'h0}, 1'b0);
    #1;
    check("read ok busy", {31'h0, array_read_ok}, 32'h0);
    host.rd(ADDR_EXT, d);
    check("ext prog", d & 32'h7, 32'h3);
    wait_idle(PROG_CYCLES - 4);
    check("read ok idle", {31'h0, array_read_ok}, 32'h1);
    query({8'h07, 18'h0}, 32'h207);
    grant(8'h07, 1'b0);
    host.cmd(CMD_ARRAY_ERASE, {8'h07, 18'h0}, 1'b0);
    #1;
    check("erase grant", {31'h0, array_op_grant}, 32'h0);
    grant(8'h03, 1'b1);
    query({8'h08, 18'h1}, 32'h008);
    host.cmd(CMD_PERSIST_ERASE, 26'h0, 1'b0);
    host.rd(ADDR_EXT, d);
    check("ext erase", d & 32'h7, 32'h5);
    wait_idle(ERASE_CYCLES - 2);
    query({8'h07, 18'h0}, 32'h107);
    grant(8'h07, 1'b1);
    host.cmd(CMD_LOCK_CLEAR, 26'h0, 1'b0);
    host.cmd(CMD_PERSIST_PROG, {8'h09, 18'h0}, 1'b0);
    host.rd(ADDR_STATUS, d);
    check("lock prog", d & 32'h1F, 32'h0A);
    host.cmd(CMD_PERSIST_ERASE, 26'h0, 1'b0);
    host.rd(ADDR_STATUS, d);
    check("lock erase", d & 32'h1C, 32'h0C);
    query({8'h09, 18'h0}, 32'h109);
    host.cmd(CMD_DYNAMIC_WRITE, {8'h05, 18'h0}, 1'b0);
    grant(8'h05, 1'b0);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    host.rd(ADDR_STATUS, d);
    check("status rereset", d, 32'h10);
    grant(8'h05, 1'b1);
    conclude();
  end
endmodule : sector_block_protect_bits_bench
